// ===== ctu_pkg.sv
// constants shared by the charge and time measurement edge control block
`default_nettype none
package ctu_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_CTL_HIGH = 8'h00;
    localparam logic [7:0] OFS_CTL_LOW  = 8'h04;
    localparam logic [7:0] OFS_CURRENT  = 8'h08;

    // reset values
    localparam logic [7:0] RST_CTL_HIGH = 8'h00;
    localparam logic [7:0] RST_CTL_LOW  = 8'h00;
    localparam logic [7:0] RST_CURRENT  = 8'h00;

    // measure_control_high fields
    localparam int HI_MODULE_ON   = 7;
    localparam int HI_IDLE_STOP   = 5;
    localparam int HI_DELAY_GEN   = 4;
    localparam int HI_EDGE_PASS   = 3;
    localparam int HI_EDGE_ORDER  = 2;
    localparam int HI_SRC_GROUND  = 1;
    localparam int HI_TRIGGER_ON  = 0;
    localparam logic [7:0] HI_WRITE_MASK = 8'hBF;

    // measure_control_low fields
    localparam int LO_CH2_POL     = 7;
    localparam int LO_CH2_SEL_LSB = 5;
    localparam int LO_CH1_POL     = 4;
    localparam int LO_CH1_SEL_LSB = 2;
    localparam int LO_CH2_SEEN    = 1;
    localparam int LO_CH1_SEEN    = 0;

    // measure_current_control fields
    localparam int CUR_RANGE_LSB = 0;
    localparam int CUR_TRIM_LSB  = 2;

    // edge source select codes
    localparam logic [1:0] SRC_PIN_ONE  = 2'h0;
    localparam logic [1:0] SRC_PIN_TWO  = 2'h1;
    localparam logic [1:0] SRC_UNIT_ONE = 2'h2;
    localparam logic [1:0] SRC_UNIT_TWO = 2'h3;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // register decode results
    localparam logic [1:0] IDX_HIGH    = 2'h0;
    localparam logic [1:0] IDX_LOW     = 2'h1;
    localparam logic [1:0] IDX_CURRENT = 2'h2;
    localparam logic [1:0] IDX_NONE    = 2'h3;

endpackage
`default_nettype wire

// ===== level_sync.sv
// two flip-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
    parameter int WIDTH = 2
) (
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);
    typedef struct packed {
        logic [WIDTH-1:0] stage1;
        logic [WIDTH-1:0] stage2;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    always_comb begin
        st_nxt        = st_r;
        st_nxt.stage1 = async_in;
        st_nxt.stage2 = st_r.stage1;
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign sync_out = st_r.stage2;
endmodule
`default_nettype wire

// ===== edge_channel.sv
// one edge channel: source select and polarity on in-domain levels
`timescale 1ns/1ps
`default_nettype none
module edge_channel (
    input  wire logic [3:0] sources,
    input  wire logic [1:0] source_sel,
    input  wire logic       polarity,
    output logic            event_level
);
    logic picked;

    always_comb begin
        case (source_sel)
            ctu_pkg::SRC_PIN_ONE:  picked = sources[0];
            ctu_pkg::SRC_PIN_TWO:  picked = sources[1];
            ctu_pkg::SRC_UNIT_ONE: picked = sources[2];
            default:               picked = sources[3];
        endcase
        // level, not transition: event follows the present level
        event_level = polarity ? picked : ~picked;
    end
endmodule
`default_nettype wire

// ===== charge_time_unit.sv
// charge time unit edge control with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit #(
    parameter int ADDR_W = 8
) (
    input  wire logic              ref_clk,
    input  wire logic              rst,
    input  wire logic              edge_pin_one,
    input  wire logic              edge_pin_two,
    input  wire logic              unit_one_event,
    input  wire logic              unit_two_event,
    input  wire logic              chip_idle,
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic [2:0]        s_axi_awprot,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic [2:0]        s_axi_arprot,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    output logic                   current_source_on,
    output logic                   source_ground,
    output logic                   delay_gen_on,
    output logic [2:0]             current_range_sel,
    output logic signed [7:0]      current_trim_pct,
    output logic                   adc_trigger
);
    typedef struct packed {
        logic [7:0]  ctl_hi;
        logic [7:0]  ctl_lo;
        logic [7:0]  cur;
        logic        aw_held;
        logic [7:0]  aw_addr;
        logic        w_held;
        logic [7:0]  w_data;
        logic        w_strb0;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        src_on;
        logic        gnd;
        logic        delay_on;
        logic        trig;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic [1:0] pins_sync;
    logic [3:0] sources;
    logic       ch1_level;
    logic       ch2_level;
    logic       active;
    logic       active_nxt;
    logic       set1;
    logic       set2;
    logic       do_write;
    logic [1:0] wr_idx;
    logic [1:0] rd_idx;

    function automatic logic [1:0] reg_index(input logic [7:0] addr);
        if (addr == ctu_pkg::OFS_CTL_HIGH) begin
            reg_index = ctu_pkg::IDX_HIGH;
        end else if (addr == ctu_pkg::OFS_CTL_LOW) begin
            reg_index = ctu_pkg::IDX_LOW;
        end else if (addr == ctu_pkg::OFS_CURRENT) begin
            reg_index = ctu_pkg::IDX_CURRENT;
        end else begin
            reg_index = ctu_pkg::IDX_NONE;
        end
    endfunction

    // pins come from outside the clock domain
    level_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .ref_clk (ref_clk),
        .rst     (rst),
        .async_in({edge_pin_two, edge_pin_one}),
        .sync_out(pins_sync)
    );

    // capture unit triggers are already on ref_clk
    assign sources = {unit_two_event, unit_one_event, pins_sync};

    edge_channel u_ch1 (
        .sources    (sources),
        .source_sel (st_r.ctl_lo[ctu_pkg::LO_CH1_SEL_LSB +: 2]),
        .polarity   (st_r.ctl_lo[ctu_pkg::LO_CH1_POL]),
        .event_level(ch1_level)
    );

    edge_channel u_ch2 (
        .sources    (sources),
        .source_sel (st_r.ctl_lo[ctu_pkg::LO_CH2_SEL_LSB +: 2]),
        .polarity   (st_r.ctl_lo[ctu_pkg::LO_CH2_POL]),
        .event_level(ch2_level)
    );

    assign wr_idx   = reg_index(st_r.aw_addr);
    assign rd_idx   = reg_index(s_axi_araddr[7:0]);
    assign do_write = st_r.aw_held & st_r.w_held & ~st_r.bvalid;

    always_comb begin
        st_nxt = st_r;
        // module runs when enabled and not stopped by idle
        active = st_r.ctl_hi[ctu_pkg::HI_MODULE_ON]
               & ~(st_r.ctl_hi[ctu_pkg::HI_IDLE_STOP] & chip_idle);
        set1 = active & st_r.ctl_hi[ctu_pkg::HI_EDGE_PASS] & ch1_level;
        set2 = active & st_r.ctl_hi[ctu_pkg::HI_EDGE_PASS] & ch2_level
             & (~st_r.ctl_hi[ctu_pkg::HI_EDGE_ORDER]
                | st_r.ctl_lo[ctu_pkg::LO_CH1_SEEN]);

        // write address and data channels, either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_nxt.aw_held = 1'b1;
            st_nxt.aw_addr = s_axi_awaddr[7:0];
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_nxt.w_held  = 1'b1;
            st_nxt.w_data  = s_axi_wdata[7:0];
            st_nxt.w_strb0 = s_axi_wstrb[0];
        end
        if (do_write) begin
            st_nxt.aw_held = 1'b0;
            st_nxt.w_held  = 1'b0;
            st_nxt.bvalid  = 1'b1;
            st_nxt.bresp   = ctu_pkg::RESP_OKAY;
            if (wr_idx == ctu_pkg::IDX_NONE) begin
                st_nxt.bresp = ctu_pkg::RESP_SLVERR;
            end else if (st_r.w_strb0) begin
                if (wr_idx == ctu_pkg::IDX_HIGH) begin
                    st_nxt.ctl_hi = st_r.w_data & ctu_pkg::HI_WRITE_MASK;
                end else if (wr_idx == ctu_pkg::IDX_LOW) begin
                    st_nxt.ctl_lo = st_r.w_data;
                end else begin
                    st_nxt.cur = st_r.w_data;
                end
            end
        end else if (st_r.bvalid && s_axi_bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // hardware set wins over a software clear in the same cycle
        st_nxt.ctl_lo[ctu_pkg::LO_CH1_SEEN] = st_nxt.ctl_lo[ctu_pkg::LO_CH1_SEEN] | set1;
        st_nxt.ctl_lo[ctu_pkg::LO_CH2_SEEN] = st_nxt.ctl_lo[ctu_pkg::LO_CH2_SEEN] | set2;

        // read channel
        if (s_axi_arvalid && s_axi_arready) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rresp  = ctu_pkg::RESP_OKAY;
            st_nxt.rdata  = 32'h0000_0000;
            if (rd_idx == ctu_pkg::IDX_HIGH) begin
                st_nxt.rdata[7:0] = st_r.ctl_hi;
            end else if (rd_idx == ctu_pkg::IDX_LOW) begin
                st_nxt.rdata[7:0] = st_r.ctl_lo;
            end else if (rd_idx == ctu_pkg::IDX_CURRENT) begin
                st_nxt.rdata[7:0] = st_r.cur;
            end else begin
                st_nxt.rresp = ctu_pkg::RESP_SLVERR;
            end
        end else if (st_r.rvalid && s_axi_rready) begin
            st_nxt.rvalid = 1'b0;
        end

        // outputs follow the registers as they will stand next cycle
        active_nxt = st_nxt.ctl_hi[ctu_pkg::HI_MODULE_ON]
                   & ~(st_nxt.ctl_hi[ctu_pkg::HI_IDLE_STOP] & chip_idle);
        st_nxt.src_on = active_nxt
                      & (st_nxt.ctl_lo[ctu_pkg::LO_CH1_SEEN]
                         ^ st_nxt.ctl_lo[ctu_pkg::LO_CH2_SEEN]);
        st_nxt.gnd      = st_nxt.ctl_hi[ctu_pkg::HI_SRC_GROUND];
        st_nxt.delay_on = active_nxt & st_nxt.ctl_hi[ctu_pkg::HI_DELAY_GEN];
        // one pulse when the second edge closes the measurement
        st_nxt.trig = active & st_r.ctl_hi[ctu_pkg::HI_TRIGGER_ON]
                    & set2 & ~st_r.ctl_lo[ctu_pkg::LO_CH2_SEEN];
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            st_r        <= '0;
            st_r.ctl_hi <= ctu_pkg::RST_CTL_HIGH;
            st_r.ctl_lo <= ctu_pkg::RST_CTL_LOW;
            st_r.cur    <= ctu_pkg::RST_CURRENT;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign s_axi_awready     = ~st_r.aw_held & ~st_r.bvalid;
    assign s_axi_wready      = ~st_r.w_held & ~st_r.bvalid;
    assign s_axi_bvalid      = st_r.bvalid;
    assign s_axi_bresp       = st_r.bresp;
    assign s_axi_arready     = ~st_r.rvalid;
    assign s_axi_rvalid      = st_r.rvalid;
    assign s_axi_rdata       = st_r.rdata;
    assign s_axi_rresp       = st_r.rresp;
    assign current_source_on = st_r.src_on;
    assign source_ground     = st_r.gnd;
    assign delay_gen_on      = st_r.delay_on;
    assign adc_trigger       = st_r.trig;

    // range code 11 selects nothing
    always_comb begin
        case (st_r.cur[ctu_pkg::CUR_RANGE_LSB +: 2])
            2'h0:    current_range_sel = 3'h1;
            2'h1:    current_range_sel = 3'h2;
            2'h2:    current_range_sel = 3'h4;
            default: current_range_sel = 3'h0;
        endcase
    end

    // two percent per signed trim step
    assign current_trim_pct = {{2{st_r.cur[7]}}, st_r.cur[7:2]} <<< 1;

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    sequence s_wr_high;
        do_write && wr_idx == ctu_pkg::IDX_HIGH && st_r.w_strb0;
    endsequence

    sequence s_wr_low;
        do_write && wr_idx == ctu_pkg::IDX_LOW && st_r.w_strb0;
    endsequence

    property p_disabled_quiet;
        !st_r.ctl_hi[ctu_pkg::HI_MODULE_ON] |-> !current_source_on && !delay_gen_on;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("outputs active while module disabled");

    property p_one_seen;
        current_source_on |->
            (st_r.ctl_lo[ctu_pkg::LO_CH1_SEEN] ^ st_r.ctl_lo[ctu_pkg::LO_CH2_SEEN]);
    endproperty
    a_one_seen: assert property (p_one_seen)
        else $error("current source on without exactly one seen bit");

    property p_seen_sets;
        set1 |=> st_r.ctl_lo[ctu_pkg::LO_CH1_SEEN];
    endproperty
    a_seen_sets: assert property (p_seen_sets)
        else $error("edge one response did not set its seen bit");

    property p_order;
        (st_r.ctl_hi[ctu_pkg::HI_EDGE_ORDER] && !st_r.ctl_lo[ctu_pkg::LO_CH1_SEEN]
         && !do_write) |=> !$rose(st_r.ctl_lo[ctu_pkg::LO_CH2_SEEN]);
    endproperty
    a_order: assert property (p_order)
        else $error("edge two accepted before edge one");

    property p_blocked;
        (!st_r.ctl_hi[ctu_pkg::HI_EDGE_PASS] && !do_write)
            |=> $stable(st_r.ctl_lo[1:0]);
    endproperty
    a_blocked: assert property (p_blocked)
        else $error("seen bits changed while edges blocked");

    property p_idle_stop;
        (st_r.ctl_hi[ctu_pkg::HI_IDLE_STOP] && chip_idle && !do_write)
            |=> $stable(st_r.ctl_lo[1:0]);
    endproperty
    a_idle_stop: assert property (p_idle_stop)
        else $error("edge recorded while stopped in idle");

    property p_trigger;
        adc_trigger |-> $past(st_r.ctl_hi[ctu_pkg::HI_TRIGGER_ON])
                        ##1 !adc_trigger;
    endproperty
    a_trigger: assert property (p_trigger)
        else $error("trigger without enable or longer than one cycle");

    property p_write_high;
        s_wr_high |=> st_r.ctl_hi == ($past(st_r.w_data) & ctu_pkg::HI_WRITE_MASK)
                      ##1 s_axi_bvalid || $past(s_axi_bready);
    endproperty
    a_write_high: assert property (p_write_high)
        else $error("control high write not applied");

    property p_write_low;
        s_wr_low |=> st_r.ctl_lo[7:2] == $past(st_r.w_data[7:2])
                     && (st_r.ctl_lo[1:0] & $past(st_r.w_data[1:0]))
                        == $past(st_r.w_data[1:0]);
    endproperty
    a_write_low: assert property (p_write_low)
        else $error("control low write not applied");

    property p_bresp;
        (st_r.aw_held && st_r.w_held && !st_r.bvalid) |=> s_axi_bvalid;
    endproperty
    a_bresp: assert property (p_bresp)
        else $error("write response late");
endmodule
`default_nettype wire

// ===== edge_source_model.sv
// far-side model: edge pins, capture unit event levels, converter trigger counter
`timescale 1ns/1ps
`default_nettype none
module edge_source_model (
    input  wire logic       ref_clk,
    input  wire logic [3:0] src_req,
    input  wire logic       adc_trigger,
    output var logic        edge_pin_one,
    output var logic        edge_pin_two,
    output var logic        unit_one_event,
    output var logic        unit_two_event,
    output var int          trig_count
);
    initial begin
        edge_pin_one = 1'b0;
        edge_pin_two = 1'b0;
        unit_one_event = 1'b0;
        unit_two_event = 1'b0;
        trig_count = 0;
    end
    // pins move off the clock grid
    always @(src_req) begin
        edge_pin_one <= #3 src_req[0];
        edge_pin_two <= #3 src_req[1];
    end
    always @(posedge ref_clk) begin
        unit_one_event <= src_req[2];
        unit_two_event <= src_req[3];
    end
    always @(posedge ref_clk) begin
        if (adc_trigger === 1'b1) trig_count <= trig_count + 1;
    end
endmodule
`default_nettype wire

// ===== charge_time_unit_test.sv
// self-checking bench for the charge time unit edge control
`timescale 1ns/1ps
`default_nettype none
module charge_time_unit_test;
    localparam logic [7:0] H = ctu_pkg::OFS_CTL_HIGH;
    localparam logic [7:0] L = ctu_pkg::OFS_CTL_LOW;
    localparam logic [7:0] C = ctu_pkg::OFS_CURRENT;
    localparam logic [1:0] OK = ctu_pkg::RESP_OKAY;
    localparam logic [7:0] ON = 8'h01 << ctu_pkg::HI_MODULE_ON;
    localparam logic [7:0] IDL = 8'h01 << ctu_pkg::HI_IDLE_STOP;
    localparam logic [7:0] DLY = 8'h01 << ctu_pkg::HI_DELAY_GEN;
    localparam logic [7:0] PAS = 8'h01 << ctu_pkg::HI_EDGE_PASS;
    localparam logic [7:0] ORD = 8'h01 << ctu_pkg::HI_EDGE_ORDER;
    localparam logic [7:0] GND = 8'h01 << ctu_pkg::HI_SRC_GROUND;
    localparam logic [7:0] TRG = 8'h01 << ctu_pkg::HI_TRIGGER_ON;
    logic        ref_clk = 1'b0;
    logic        rst = 1'b1;
    logic [3:0]  src = 4'h0;
    logic        idle = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp, rsp;
    logic [31:0] rdata;
    logic        pin1, pin2, ev1, ev2, cur_on, gnd, dly, trig;
    logic [2:0]  rng;
    logic signed [7:0] trim;
    logic [7:0]  rv;
    int          trig_count, n0;
    int          fail_count = 0;
    int          num_checks = 0;
    logic [2:0]  rtab [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
    logic [5:0]  ttab [4] = '{6'h00, 6'h20, 6'h1F, 6'h01};
    logic [7:0]  ptab [4] = '{8'h00, 8'hC0, 8'h3E, 8'h02};

    always #5 ref_clk = ~ref_clk;

    charge_time_unit i_charge_time_unit (.ref_clk(ref_clk), .rst(rst),
        .edge_pin_one(pin1), .edge_pin_two(pin2), .unit_one_event(ev1),
        .unit_two_event(ev2), .chip_idle(idle), .s_axi_awaddr(awaddr),
        .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .current_source_on(cur_on), .source_ground(gnd), .delay_gen_on(dly),
        .current_range_sel(rng), .current_trim_pct(trim), .adc_trigger(trig));
    edge_source_model i_edge_source_model (.ref_clk(ref_clk), .src_req(src),
        .adc_trigger(trig), .edge_pin_one(pin1), .edge_pin_two(pin2),
        .unit_one_event(ev1), .unit_two_event(ev2), .trig_count(trig_count));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        logic pa, pw, ta, tw, got;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        got = 1'b0;
        @(posedge ref_clk);
        awaddr <= a;
        wdata <= {24'h0, d};
        wstrb <= 4'hF;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while ((pa || pw) && n < 50) begin
            @(negedge ref_clk);
            ta = pa && (awready === 1'b1);
            tw = pw && (wready === 1'b1);
            @(posedge ref_clk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            pa = pa && !ta;
            pw = pw && !tw;
            n++;
        end
        while (!got && n < 100) begin
            @(negedge ref_clk);
            got = (bvalid === 1'b1);
            rsp = bresp;
            @(posedge ref_clk);
            n++;
        end
        bready <= 1'b0;
        chk(got, 1'b1);
        chk(rsp, er);
    endtask

    task automatic rd(input logic [7:0] a, input logic [1:0] er);
        int n;
        logic got;
        logic [23:0] hi;
        n = 0;
        got = 1'b0;
        @(posedge ref_clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!got && n < 50) begin
            @(negedge ref_clk);
            got = (arready === 1'b1);
            @(posedge ref_clk);
            n++;
        end
        arvalid <= 1'b0;
        got = 1'b0;
        while (!got && n < 100) begin
            @(negedge ref_clk);
            got = (rvalid === 1'b1);
            rv = rdata[7:0];
            hi = rdata[31:8];
            rsp = rresp;
            @(posedge ref_clk);
            n++;
        end
        rready <= 1'b0;
        chk(got, 1'b1);
        chk(rsp, er);
        chk(hi, 24'h0);
    endtask

    task automatic setsrc(input logic [3:0] s);
        @(posedge ref_clk);
        src <= s;
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge ref_clk);
        @(negedge ref_clk);
    endtask

    task automatic seen(input logic [1:0] e);
        rd(L, OK);
        chk(rv[1:0], e);
    endtask

    // clears seen bits while disabled, then applies the new setup
    task automatic restart(input logic [7:0] lo, input logic [7:0] hi, input logic [3:0] s);
        setsrc(4'h0);
        wr(H, 8'h00, OK);
        wr(L, lo, OK);
        setsrc(s);
        wr(H, hi, OK);
        n0 = trig_count;
    endtask

    task automatic t_regs;
        rd(H, OK);
        chk(rv, ctu_pkg::RST_CTL_HIGH);
        rd(L, OK);
        chk(rv, ctu_pkg::RST_CTL_LOW);
        rd(C, OK);
        chk(rv, ctu_pkg::RST_CURRENT);
        rd(8'h0C, ctu_pkg::RESP_SLVERR);
        chk(rv, 8'h00);
        wr(8'h0C, 8'hFF, ctu_pkg::RESP_SLVERR);
        wr(H, 8'h40, OK);
        rd(H, OK);
        chk(rv, 8'h00);
        $display("test regs done");
    endtask

    task automatic t_current;
        for (int i = 0; i < 4; i++) begin
            wr(C, {ttab[i], i[1:0]}, OK);
            @(negedge ref_clk);
            chk(rng, rtab[i]);
            chk($unsigned(trim), ptab[i]);
            rd(C, OK);
            chk(rv, {ttab[i], i[1:0]});
        end
        $display("test current done");
    endtask

    task automatic t_sources;
        logic [3:0] oth;
        for (int i = 0; i < 4; i++) begin
            oth = ~(4'h1 << i) & 4'h7;
            restart(8'hF0 | {i[5:0], 2'h0}, ON | PAS, oth);
            waitc(6);
            seen(2'h0);
            setsrc(oth | (4'h1 << i));
            waitc(6);
            seen((i == 3) ? 2'h3 : 2'h1);
        end
        $display("test sources done");
    endtask

    task automatic t_measure;
        restart(8'hF0, ON | PAS | TRG | DLY | GND, 4'h0);
        waitc(6);
        chk(cur_on, 1'b0);
        chk(dly, 1'b1);
        chk(gnd, 1'b1);
        setsrc(4'h1);
        waitc(6);
        chk(cur_on, 1'b1);
        seen(2'h1);
        setsrc(4'h9);
        waitc(6);
        chk(cur_on, 1'b0);
        seen(2'h3);
        chk(trig_count - n0, 1);
        restart(8'hF0, ON | PAS, 4'h9);
        waitc(6);
        seen(2'h3);
        chk(trig_count - n0, 0);
        chk(dly, 1'b0);
        chk(gnd, 1'b0);
        $display("test measure done");
    endtask

    task automatic t_gates;
        restart(8'hF0, PAS | TRG | DLY, 4'h9);
        waitc(6);
        seen(2'h0);
        chk(cur_on | dly, 1'b0);
        chk(trig_count - n0, 0);
        restart(8'hF0, ON | TRG, 4'h9);
        waitc(6);
        seen(2'h0);
        restart(8'hF0, ON | PAS | ORD, 4'h8);
        waitc(6);
        seen(2'h0);
        setsrc(4'h9);
        waitc(6);
        seen(2'h3);
        restart(8'hF0, ON | PAS, 4'h8);
        waitc(6);
        seen(2'h2);
        restart(8'hF0, ON | PAS, 4'h0);
        wr(L, 8'hE0, OK);
        waitc(4);
        seen(2'h1);
        $display("test gates done");
    endtask

    task automatic t_idle;
        @(posedge ref_clk);
        idle <= 1'b1;
        restart(8'hF0, ON | PAS | IDL | DLY, 4'h1);
        waitc(6);
        seen(2'h0);
        chk(dly, 1'b0);
        @(posedge ref_clk);
        idle <= 1'b0;
        waitc(6);
        seen(2'h1);
        @(posedge ref_clk);
        idle <= 1'b1;
        restart(8'hF0, ON | PAS, 4'h1);
        waitc(6);
        seen(2'h1);
        @(posedge ref_clk);
        idle <= 1'b0;
        $display("test idle done");
    endtask

    task automatic t_soft;
        restart(8'hF0, ON, 4'h0);
        for (int i = 0; i < 4; i++) begin
            wr(L, 8'hF0 | i[7:0], OK);
            waitc(1);
            chk(cur_on, (i == 1 || i == 2));
            seen(i[1:0]);
        end
        $display("test soft done");
    endtask

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        t_regs();
        t_current();
        t_sources();
        t_measure();
        t_gates();
        t_idle();
        t_soft();
        tally_and_finish();
    end

    initial begin
        #400000;
        fail_count++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
